// ===== include/nv_ram_pkg.sv
// Constants, types and the protect key table for the nonvolatile RAM host.
// Assumes a 125 MHz core clock and a 17-bit word address memory outside.
package nv_ram_pkg;

  localparam int unsigned ADDR_W   = 17;
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned COL_W    = 2;
  localparam int unsigned CNT_W    = 16;
  localparam int unsigned SYNC_CYC = 2;
  localparam int unsigned CLK_NS   = 8;

  // Pin timing in ns, plain defaults; cycle counts round up
  localparam int unsigned ACCESS_NS    = 70;
  localparam int unsigned PAGE_NS      = 30;
  localparam int unsigned PRECHARGE_NS = 70;
  localparam int unsigned WAKE_NS      = 450;
  localparam int unsigned ACC_CYC  = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PAGE_CYC = (PAGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PC_CYC   = (PRECHARGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;

  // Protect key sequence: six reads, three writes, one closing read
  localparam int unsigned     SEQ_LEN    = 10;
  localparam logic [3:0]      SEQ_LAST   = 4'h9;
  localparam logic [3:0]      STEP_BYTE  = 4'h6;
  localparam logic [3:0]      STEP_CMPL  = 4'h7;
  localparam logic [9:0]      SEQ_WR_MSK = 10'h01c0;
  localparam logic [ADDR_W-1:0] KEY_ADDR [SEQ_LEN] = '{
    17'h1_2555, 17'h1_daaa, 17'h0_1333, 17'h0_eccc, 17'h0_00ff,
    17'h1_ff00, 17'h1_daaa, 17'h0_eccc, 17'h0_ff00, 17'h0_0000};

  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
  localparam logic [7:0]        BYTE_ZERO = 8'h00;

  typedef logic [CNT_W-1:0] cnt_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_START  = 3'h1,
    ST_ACCESS = 3'h3,
    ST_PRECHG = 3'h2,
    ST_SLEEP  = 3'h4,
    ST_WAKE   = 3'h5
  } host_state_e;

  // One request from user logic; byte_en is active high
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0]        byte_en;
  } mem_req_s;

  // Everything driven toward the memory pins
  typedef struct packed {
    logic [ADDR_W-1:0] word_address;
    logic              chip_sel_n;
    logic              write_strobe_n;
    logic              out_drive_n;
    logic              upper_byte_sel_n;
    logic              lower_byte_sel_n;
    logic              sleep_request_n;
    logic [DATA_W-1:0] data_pins_o;
    logic              data_pins_oe;
  } pin_out_s;

endpackage

// ===== design/nv_ram_host.sv
// Host controller driving an asynchronous 128K x 16 nonvolatile RAM.
// Assumes the data pins resolve outside from data_pins_oe; core_clk 125 MHz.
//
// What this block does
// - Host holds write for access time, data stable before the end edge.
// - One write strobe pulse per word; no busy polling needed.
// - Select high starts precharge; host keeps it high the minimum time.
// - Host finishes accesses before sleep, ties sleep high if unused.
// - Protect change: six key reads, byte write, complement write, zero write, read.
// - Key addresses 12555h 1DAAAh 01333h 0ECCCh 000FFh 1FF00h, then writes.
`timescale 1ns/1ps
`default_nettype none

module nv_ram_host #(
  parameter int unsigned ACC_CYCLES  = nv_ram_pkg::ACC_CYC,
  parameter int unsigned PAGE_CYCLES = nv_ram_pkg::PAGE_CYC,
  parameter int unsigned PC_CYCLES   = nv_ram_pkg::PC_CYC,
  parameter int unsigned WAKE_CYCLES = nv_ram_pkg::WAKE_CYC
) (
  input  wire logic                         core_clk,
  input  wire logic                         rstn,
  input  wire logic                         req_valid,
  input  wire nv_ram_pkg::mem_req_s         req,
  output var  logic                         req_taken,
  output var  logic                         resp_valid,
  output var  logic [nv_ram_pkg::DATA_W-1:0] resp_rdata,
  input  wire logic                         prot_valid,
  input  wire logic [7:0]                   prot_byte,
  output var  logic                         prot_done,
  input  wire logic                         sleep_req,
  output var  logic                         asleep,
  input  wire logic [nv_ram_pkg::DATA_W-1:0] data_pins_i,
  output var  nv_ram_pkg::pin_out_s         mem_pins
);
  import nv_ram_pkg::*;

  localparam cnt_t ACC_LOAD  = cnt_t'(ACC_CYCLES - 1);
  localparam cnt_t RD_LOAD   = cnt_t'(ACC_CYCLES + SYNC_CYC - 1);
  localparam cnt_t PAGE_LOAD = cnt_t'(PAGE_CYCLES + SYNC_CYC - 1);
  localparam cnt_t PC_LOAD   = cnt_t'(PC_CYCLES - 1);
  localparam cnt_t WAKE_LOAD = cnt_t'(WAKE_CYCLES - 1);
  localparam cnt_t CNT_ZERO  = '0;

  host_state_e       state_r;
  cnt_t              cnt_r;
  logic              cur_write_r;
  logic              cur_user_r;
  logic              seq_active_r;
  logic [3:0]        seq_step_r;
  logic [7:0]        prot_byte_r;
  logic [DATA_W-1:0] din_s1_r;
  logic [DATA_W-1:0] din_s2_r;
  mem_req_s          seq_cmd;
  mem_req_s          cmd;
  logic              in_idle;
  logic              issue_seq;
  logic              issue_user;
  logic              start_prot;
  logic              go_sleep;
  logic              acc_done;
  logic              page_take;

  // Key sequence command for the current step
  always_comb begin
    seq_cmd.write   = SEQ_WR_MSK[seq_step_r];
    seq_cmd.addr    = KEY_ADDR[seq_step_r];
    seq_cmd.byte_en = 2'h3;
    if (seq_step_r == STEP_BYTE) begin
      seq_cmd.wdata = {BYTE_ZERO, prot_byte_r};
    end else if (seq_step_r == STEP_CMPL) begin
      seq_cmd.wdata = {BYTE_ZERO, ~prot_byte_r};
    end else begin
      seq_cmd.wdata = DATA_ZERO;
    end
  end

  // Issue decisions: running sequence, then protect, sleep, user
  assign in_idle    = (state_r == ST_IDLE);
  assign issue_seq  = in_idle && seq_active_r;
  assign start_prot = in_idle && !seq_active_r && prot_valid;
  assign go_sleep   = in_idle && !seq_active_r && !prot_valid && sleep_req;
  assign issue_user = in_idle && !seq_active_r && !prot_valid && !sleep_req
                      && req_valid;
  assign cmd        = issue_seq ? seq_cmd : req;
  assign acc_done   = (state_r == ST_ACCESS) && (cnt_r == CNT_ZERO);
  // Same-row user read may follow as a page access with select held low
  assign page_take  = acc_done && !cur_write_r && cur_user_r
                      && !prot_valid && !sleep_req && req_valid
                      && !req.write
                      && (req.addr[ADDR_W-1:COL_W]
                          == mem_pins.word_address[ADDR_W-1:COL_W]);

  // Two-stage synchroniser on the returning data pins
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      din_s1_r <= DATA_ZERO;
      din_s2_r <= DATA_ZERO;
    end else begin
      din_s1_r <= data_pins_i;
      din_s2_r <= din_s1_r;
    end
  end

  // Access state machine and pin drive
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r                   <= ST_IDLE;
      cnt_r                     <= CNT_ZERO;
      cur_write_r               <= 1'b0;
      cur_user_r                <= 1'b0;
      mem_pins.word_address     <= '0;
      mem_pins.chip_sel_n       <= 1'b1;
      mem_pins.write_strobe_n   <= 1'b1;
      mem_pins.out_drive_n      <= 1'b1;
      mem_pins.upper_byte_sel_n <= 1'b1;
      mem_pins.lower_byte_sel_n <= 1'b1;
      mem_pins.sleep_request_n  <= 1'b1;
      mem_pins.data_pins_o      <= DATA_ZERO;
      mem_pins.data_pins_oe     <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (issue_seq || issue_user) begin
            // Address, byte selects and strobe settle before select falls
            mem_pins.word_address     <= cmd.addr;
            mem_pins.upper_byte_sel_n <= !cmd.byte_en[1];
            mem_pins.lower_byte_sel_n <= !cmd.byte_en[0];
            mem_pins.write_strobe_n   <= !cmd.write;
            mem_pins.data_pins_o      <= cmd.wdata;
            mem_pins.data_pins_oe     <= cmd.write;
            cur_write_r               <= cmd.write;
            cur_user_r                <= issue_user;
            state_r                   <= ST_START;
          end else if (go_sleep) begin
            mem_pins.sleep_request_n <= 1'b0;
            state_r                  <= ST_SLEEP;
          end
        end
        ST_START: begin
          mem_pins.chip_sel_n  <= 1'b0;
          mem_pins.out_drive_n <= cur_write_r;
          cnt_r                <= cur_write_r ? ACC_LOAD : RD_LOAD;
          state_r              <= ST_ACCESS;
        end
        ST_ACCESS: begin
          if (page_take) begin
            mem_pins.word_address     <= req.addr;
            mem_pins.upper_byte_sel_n <= !req.byte_en[1];
            mem_pins.lower_byte_sel_n <= !req.byte_en[0];
            cnt_r                     <= PAGE_LOAD;
          end else if (acc_done) begin
            // Strobe and select rise together, ending the write
            mem_pins.write_strobe_n <= 1'b1;
            mem_pins.chip_sel_n     <= 1'b1;
            mem_pins.out_drive_n    <= 1'b1;
            cnt_r                   <= PC_LOAD;
            state_r                 <= ST_PRECHG;
          end else begin
            cnt_r <= cnt_r - cnt_t'(1);
          end
        end
        ST_PRECHG: begin
          // Write data held one cycle past the ending edge, then released
          mem_pins.data_pins_oe <= 1'b0;
          if (cnt_r == CNT_ZERO) begin
            state_r <= ST_IDLE;
          end else begin
            cnt_r <= cnt_r - cnt_t'(1);
          end
        end
        ST_SLEEP: begin
          if (!sleep_req) begin
            mem_pins.sleep_request_n <= 1'b1;
            cnt_r                    <= WAKE_LOAD;
            state_r                  <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (cnt_r == CNT_ZERO) begin
            state_r <= ST_IDLE;
          end else begin
            cnt_r <= cnt_r - cnt_t'(1);
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Protect key sequencer: one step per issued access
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      seq_active_r <= 1'b0;
      seq_step_r   <= 4'h0;
      prot_byte_r  <= BYTE_ZERO;
      prot_done    <= 1'b0;
    end else begin
      prot_done <= 1'b0;
      if (start_prot) begin
        seq_active_r <= 1'b1;
        seq_step_r   <= 4'h0;
        prot_byte_r  <= prot_byte;
      end else if (issue_seq) begin
        if (seq_step_r == SEQ_LAST) begin
          seq_active_r <= 1'b0;
          seq_step_r   <= 4'h0;
          prot_done    <= 1'b1;
        end else begin
          seq_step_r <= seq_step_r + 4'h1;
        end
      end
    end
  end

  // User handshake, read data return and sleep status
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      req_taken  <= 1'b0;
      resp_valid <= 1'b0;
      resp_rdata <= DATA_ZERO;
      asleep     <= 1'b0;
    end else begin
      req_taken  <= issue_user || page_take;
      resp_valid <= acc_done && cur_user_r;
      if (acc_done && !cur_write_r) begin
        resp_rdata <= din_s2_r;
      end
      asleep <= (state_r == ST_SLEEP);
    end
  end

endmodule // nv_ram_host

`default_nettype wire

// ===== verification/nv_ram_chk.sv
// Assertions on the pins that the host drives toward the memory.
// Bound into nv_ram_host below; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module nv_ram_chk #(
  parameter int unsigned ACC_CYCLES = 2,
  parameter int unsigned PC_CYCLES  = 1
) (
  input wire logic                 core_clk,
  input wire logic                 rstn,
  input wire logic                 prot_done,
  input wire logic                 asleep,
  input wire nv_ram_pkg::pin_out_s mem_pins
);
  import nv_ram_pkg::*;
  cnt_t lo_r;
  cnt_t hi_r;
  wire  cs_n = mem_pins.chip_sel_n;
  wire  we_n = mem_pins.write_strobe_n;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  // Length of the current low and high spans of chip select
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lo_r <= 16'h0000;
      hi_r <= 16'h0100;
    end else begin
      lo_r <= cs_n ? 16'h0000 : lo_r + 16'h0001;
      hi_r <= cs_n ? hi_r + 16'h0001 : 16'h0000;
    end
  end
  a_cs_low_span: assert property ($rose(cs_n) |-> lo_r >= ACC_CYCLES)
    else $error("chip select low too short");
  a_precharge_min: assert property ($fell(cs_n) |-> hi_r >= PC_CYCLES)
    else $error("precharge too short");
  a_strobe_lead: assert property ($fell(we_n) |-> cs_n)
    else $error("write strobe fell with select low");
  a_strobe_end: assert property ($rose(we_n) |-> $rose(cs_n))
    else $error("write strobe rose apart from select");
  a_wr_data_hold: assert property (!we_n && !$past(we_n) |->
    mem_pins.data_pins_oe && $stable(mem_pins.data_pins_o))
    else $error("write data moved during write");
  a_read_release: assert property (!mem_pins.out_drive_n |->
    !mem_pins.data_pins_oe && we_n)
    else $error("host drives bus during read");
  a_row_steady: assert property (!cs_n && !$past(cs_n) |->
    $stable(mem_pins.word_address[16:2]))
    else $error("row moved with select low");
  a_sleep_quiet: assert property (!mem_pins.sleep_request_n |-> cs_n && we_n)
    else $error("access during sleep");
  // Main scenarios reached
  c_write: cover property ($rose(we_n));
  c_prot: cover property (prot_done);
  c_sleep: cover property (asleep);
endmodule // nv_ram_chk
bind nv_ram_host nv_ram_chk #(
  .ACC_CYCLES(ACC_CYCLES),
  .PC_CYCLES(PC_CYCLES)
) i_chk (
  .core_clk(core_clk),
  .rstn(rstn),
  .prot_done(prot_done),
  .asleep(asleep),
  .mem_pins(mem_pins)
);
`default_nettype wire

// ===== verification/nv_ram_dev.sv
// Behavioural 128K x 16 nonvolatile RAM with sector write protect.
// Watches the host pins; the bench resolves the shared data bus.
`timescale 1ns/1ps
`default_nettype none
module nv_ram_dev #(
  parameter int T_ACC  = 15,
  parameter int T_PAGE = 6,
  parameter int T_WAKE = 20
) (
  input  wire nv_ram_pkg::pin_out_s           mem_pins,
  input  wire logic [nv_ram_pkg::DATA_W-1:0]  bus,
  output var  logic [nv_ram_pkg::DATA_W-1:0]  rd_data,
  output var  logic [1:0]                     rd_oe
);
  import nv_ram_pkg::*;
  logic [15:0] mem [0:131071];
  logic [16:0] a_r = '0;
  logic [7:0]  prot_r = 8'h00;
  logic [7:0]  pend_r = 8'h00;
  logic [3:0]  step_r = 4'h0;
  logic        wr_r = 1'b0;
  logic        open_r = 1'b0;
  logic        rdy_r = 1'b0;
  logic        awake_r = 1'b1;
  logic [16:0] key [6] = '{17'h1_2555, 17'h1_daaa, 17'h0_1333,
    17'h0_eccc, 17'h0_00ff, 17'h1_ff00};
  wire [16:0] addr = mem_pins.word_address;
  wire cs_n = mem_pins.chip_sel_n;
  wire we_n = mem_pins.write_strobe_n;
  wire live = mem_pins.sleep_request_n && awake_r;
  // Array content is known so reads show array data
  initial for (int i = 0; i < 131072; i++) mem[i] = ~i[15:0];
  // Falling select latches the address and opens a read or write
  always @(negedge cs_n) if (live) begin
    a_r = addr;
    open_r = 1'b1;
    wr_r = !we_n;
    rdy_r = 1'b0;
    rdy_r <= #(T_ACC) 1'b1;
  end
  // Address moves with select low: column is fast, row reopens
  always @(addr) if (!cs_n && live) begin
    rdy_r = 1'b0;
    rdy_r <= #((addr[16:2] == a_r[16:2]) ? T_PAGE : T_ACC) 1'b1;
    a_r = addr;
  end
  // A later strobe turns the open cycle into a write
  always @(negedge we_n) if (!cs_n && live) wr_r = 1'b1;
  // End of access: store unless held by the sequencer or a sector flag
  always @(posedge we_n or posedge cs_n) begin
    if (wr_r && !(step_r inside {6, 7, 8}) && !prot_r[a_r[16:14]]) begin
      if (!mem_pins.upper_byte_sel_n) mem[a_r][15:8] = bus[15:8];
      if (!mem_pins.lower_byte_sel_n) mem[a_r][7:0] = bus[7:0];
    end
    if (cs_n && open_r) begin
      case (step_r)
        6: step_r = wr_r ? 4'h7 : 4'h0;
        7: step_r = (wr_r && bus[7:0] == ~pend_r) ? 4'h8 : 4'h0;
        8: step_r = 4'h9;
        9: step_r = 4'h0;
        default: step_r = (!wr_r && a_r == key[step_r]) ? step_r + 1 : 0;
      endcase
      if (step_r == 7) pend_r = bus[7:0];
      if (step_r == 8) prot_r = pend_r;
      open_r = 1'b0;
      wr_r = 1'b0;
    end
  end
  // Leaving sleep refuses access for the wake delay
  always @(posedge mem_pins.sleep_request_n) begin
    awake_r = 1'b0;
    awake_r <= #(T_WAKE) 1'b1;
  end
  // Drive only valid data, on selected lanes, with the strobe high
  assign rd_data = mem[a_r];
  assign rd_oe = {2{!cs_n && !mem_pins.out_drive_n && we_n && rdy_r && live}}
    & ~{mem_pins.upper_byte_sel_n, mem_pins.lower_byte_sel_n};
endmodule // nv_ram_dev
`default_nettype wire

// ===== verification/nv_ram_host_bench.sv
// Self-checking bench: nv_ram_host against the behavioural memory.
// Needs nv_ram_pkg, nv_ram_host, nv_ram_dev and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module nv_ram_host_bench;
  import nv_ram_pkg::*;
  logic              core_clk = 1'b0;
  logic              rstn = 1'b0;
  logic              req_valid = 1'b0;
  logic              prot_valid = 1'b0;
  logic              sleep_req = 1'b0;
  logic [7:0]        prot_byte = 8'h18;
  mem_req_s          req = '0;
  logic              req_taken;
  logic              resp_valid;
  logic              prot_done;
  logic              asleep;
  logic [DATA_W-1:0] resp_rdata;
  logic [DATA_W-1:0] m_data;
  logic [DATA_W-1:0] last_r = 16'h0000;
  logic [DATA_W-1:0] got [2];
  logic [1:0]        m_oe;
  wire  [DATA_W-1:0] bus;
  pin_out_s          mem_pins;
  int                bad_count = 0;
  int                total_checks = 0;
  nv_ram_host #(.ACC_CYCLES(3), .PAGE_CYCLES(2), .PC_CYCLES(2),
    .WAKE_CYCLES(4)) i_dut (
    .core_clk(core_clk), .rstn(rstn), .req_valid(req_valid), .req(req),
    .req_taken(req_taken), .resp_valid(resp_valid),
    .resp_rdata(resp_rdata), .prot_valid(prot_valid),
    .prot_byte(prot_byte), .prot_done(prot_done), .sleep_req(sleep_req),
    .asleep(asleep), .data_pins_i(bus), .mem_pins(mem_pins));
  nv_ram_dev i_mem (.mem_pins(mem_pins), .bus(bus), .rd_data(m_data),
    .rd_oe(m_oe));
  // Bus: host, else memory lane, else the inverse of the last value
  assign bus[15:8] = mem_pins.data_pins_oe ? mem_pins.data_pins_o[15:8] :
    m_oe[1] ? m_data[15:8] : ~last_r[15:8];
  assign bus[7:0] = mem_pins.data_pins_oe ? mem_pins.data_pins_o[7:0] :
    m_oe[0] ? m_data[7:0] : ~last_r[7:0];
  always @(posedge core_clk) last_r <= bus;
  initial forever #4 core_clk = ~core_clk;
  // Verdict and end of run
  task automatic final_report();
    if (bad_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Compare one word
  task automatic check(input string what, input logic [15:0] exp, act);
    total_checks++;
    if (act !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, act);
    end
  endtask
  task automatic timeout();
    check("wait bound", 16'h0001, 16'h0000);
    final_report();
  endtask
  function automatic mem_req_s rq(logic w, logic [16:0] a, logic [15:0] d,
    logic [1:0] be);
    rq = '{w, a, d, be};
  endfunction
  // One request, or two reads of one row to reach page mode
  task automatic xfer(input mem_req_s a, b, input int n);
    int t = 0;
    int r = 0;
    @(negedge core_clk);
    req = a;
    req_valid = 1'b1;
    for (int i = 0; i < 400 && r < n; i++) begin
      @(negedge core_clk);
      if (resp_valid === 1'b1) begin
        got[r] = resp_rdata;
        r++;
      end
      if (req_taken === 1'b1) begin
        t++;
        if (t < n) req = b;
        else req_valid = 1'b0;
      end
    end
    if (r < n) timeout();
  endtask
  // Whole word, lower lane only, then a page pair
  task automatic t_write_read();
    xfer(rq(1, 17'h0_0123, 16'h5aa5, 2'b11), req, 1);
    xfer(rq(1, 17'h0_0123, 16'hc3c3, 2'b01), req, 1);
    xfer(rq(0, 17'h0_0123, 0, 2'b11), req, 1);
    check("lane write", 16'h5ac3, got[0]);
    xfer(rq(0, 17'h0_0122, 0, 2'b11), rq(0, 17'h0_0123, 0, 2'b11), 2);
    check("first word", 16'hfedd, got[0]);
    check("page word", 16'h5ac3, got[1]);
  endtask
  // Protect sectors 3 and 4, then write around their edges
  task automatic t_protect();
    logic [16:0] a [4] = '{17'h0_c000, 17'h0_bfff, 17'h1_3fff, 17'h1_4000};
    int i = 0;
    @(negedge core_clk);
    prot_valid = 1'b1;
    while (prot_done !== 1'b1 && i < 300) begin
      @(negedge core_clk);
      i++;
    end
    prot_valid = 1'b0;
    if (i == 300) timeout();
    foreach (a[k]) begin
      xfer(rq(1, a[k], 16'h2222, 2'b11), req, 1);
      xfer(rq(0, a[k], 0, 2'b11), req, 1);
      check("sector word", prot_byte[a[k][16:14]] ? ~a[k][15:0] : 16'h2222,
        got[0]);
    end
    xfer(rq(0, 17'h1_daaa, 0, 2'b11), req, 1);
    check("byte write kept out", 16'h2555, got[0]);
    xfer(rq(0, 17'h0_eccc, 0, 2'b11), req, 1);
    check("complement kept out", 16'h1333, got[0]);
  endtask
  // Sleep, wake, then a read must still work
  task automatic t_sleep();
    int i = 0;
    @(negedge core_clk);
    sleep_req = 1'b1;
    while (asleep !== 1'b1 && i < 50) begin
      @(negedge core_clk);
      i++;
    end
    if (i == 50) timeout();
    check("sleep pin", 16'h0000, {15'h0, mem_pins.sleep_request_n});
    sleep_req = 1'b0;
    xfer(rq(0, 17'h0_0123, 0, 2'b11), req, 1);
    check("read after wake", 16'h5ac3, got[0]);
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    rstn = 1'b1;
    t_write_read();
    t_protect();
    t_sleep();
    final_report();
  end
endmodule // nv_ram_host_bench
`default_nettype wire
